// ===== rtl/mcb_consts.svh
// Constants for the configuration bank
// Contract
// - After lock is set every register ignores host writes and keeps contents.
// - Bit 0 of special function: 0 sleep (reset), 1 shutdown.
// - Bit 1 of special function: 0 continuous (reset), 1 cycle monitoring.
// - Bit 2 enables alert pin output function; reset disabled.
// - Bit 3 lets out-of-limit voltages drive alert pin low; reset off.
// - Bit 4 routes temperature offset: 0 external (reset), 1 internal.
// - Averaging 0: diodes average 128, voltages and internal average 8.
// - Averaging 1 (reset): diodes average 16, voltages and internal unaveraged.
// - Bits 6 and 7 gate diode 1 and diode 2 alarm status; reset enabled.
// - Voltage enable bits gate rail status bits, 1.5V at bit 0 to VCC.
// - Configuration bit 1 enables the alert pin.
// - Readings valid flag reads 1 only after valid readings following start.
// - Spin-up shortening enable, reset 1, ends spin-up early from tach feedback.
// - Fan/temp enable: pin routing bits 0 and 5, fan 1-4 and ambient gates.
// - Two-bit field per tach selects PWM1..3; code 11 reserved.
// - No tach status while its PWM duty is zero or fan disabled.
// - No tach status when its minimum limit is all ones.
// - Sync pulse register bit 4 switches active-low sync pulse; default on.
`ifndef MCB_CONSTS_SVH
`define MCB_CONSTS_SVH

// ============================================================
// Register offsets
`define MCB_OFF_SFC        8'h7C
`define MCB_OFF_VOLT_EN    8'h7E
`define MCB_OFF_CFG        8'h7F
`define MCB_OFF_FT_EN      8'h80
`define MCB_OFF_TACH_MAP   8'h81
`define MCB_OFF_SYNC       8'h83

// ============================================================
// Reset values and writable masks
`define MCB_RST_SFC        8'hE0
`define MCB_RST_VOLT_EN    8'hEC
`define MCB_RST_CFG        8'h10
`define MCB_RST_FT_EN      8'h5E
`define MCB_RST_TACH_MAP   8'hA4
`define MCB_RST_SYNC       8'h62
`define MCB_WM_ALL         8'hFF
`define MCB_WM_CFG         8'hD2
`define MCB_WM_FT_EN       8'h7F
`define MCB_WM_SYNC        8'h10

// ============================================================
// Field positions
`define MCB_SFC_IDLE       0
`define MCB_SFC_SCAN       1
`define MCB_SFC_PIN_EN     2
`define MCB_SFC_RAIL_PIN   3
`define MCB_SFC_OFFSET     4
`define MCB_SFC_AVG        5
`define MCB_SFC_D1         6
`define MCB_SFC_D2         7
`define MCB_CFG_ALERT      1
`define MCB_CFG_VALID      3
`define MCB_CFG_SPINUP     4
`define MCB_CFG_TACH_TEST  6
`define MCB_CFG_INIT       7
`define MCB_FT_FAN_PIN     0
`define MCB_FT_FAN_LO      1
`define MCB_FT_FAN_HI      4
`define MCB_FT_TEMP_PIN    5
`define MCB_FT_ROOM        6
`define MCB_SYNC_ON        4

// ============================================================
// Averaging depths
`define MCB_AVG_DIODE_DEEP 8'h80
`define MCB_AVG_DIODE_FAST 8'h10
`define MCB_AVG_RAIL_DEEP  8'h08
`define MCB_AVG_RAIL_FAST  8'h01

`endif

// ===== rtl/mcb_pkg.sv
// Types shared by the monitor configuration bank
package mcb_pkg;
    typedef logic [7:0] mcb_byte_t;
    typedef enum logic [1:0] {
        MCB_PWM1 = 2'b00,
        MCB_PWM2 = 2'b01,
        MCB_PWM3 = 2'b10,
        MCB_PWM_RSVD = 2'b11
    } mcb_pwm_sel_t;
endpackage

// ===== rtl/mcb_lock_reg.sv
// Lockable register byte; reserved bits stay at reset
`timescale 1ns/100ps
module mcb_lock_reg
    import mcb_pkg::*;
#(
    parameter mcb_byte_t RESET_VAL = 8'h00,
    parameter mcb_byte_t WR_MASK   = 8'hFF
)(
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    // Host write
    input  wire logic      wr_hit,
    input  wire logic      lock_active,
    input  wire mcb_byte_t wr_data,
    // Stored value
    output mcb_byte_t      value
);
    mcb_byte_t value_reg;
    mcb_byte_t value_next;

    // ============================================================
    // Update
    always_comb
    begin
        value_next = value_reg;
        if (wr_hit && !lock_active)
        begin
            value_next = (value_reg & ~WR_MASK) | (wr_data & WR_MASK);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            value_reg <= RESET_VAL;
        else
            value_reg <= value_next;
    end

    assign value = value_reg;

    // ============================================================
    // Checks
    property p_lock_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (wr_hit && lock_active) |=> $stable(value_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked register changed on write");

    property p_rsvd_fixed;
        @(posedge core_clk) disable iff (sys_rst)
        ((value_reg & ~WR_MASK) == (RESET_VAL & ~WR_MASK));
    endproperty
    a_rsvd_fixed: assert property (p_rsvd_fixed)
        else $error("reserved bit left its reset value");
endmodule

// ===== rtl/mcb_tach_gate.sv
// Gate for one tachometer event against its mapped PWM
`timescale 1ns/100ps
module mcb_tach_gate
    import mcb_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Mapping and fan state
    input  wire logic [1:0] map_code,
    input  wire logic [2:0] pwm_duty_zero,
    input  wire logic [2:0] pwm_fan_off,
    input  wire logic       min_all_ones,
    input  wire logic       enable,
    // Event in, status set out
    input  wire logic       tach_event,
    output logic            status_set
);
    logic pwm_quiet;

    // ============================================================
    // PWM lookup; reserved code keeps the tach silent
    always_comb
    begin
        unique case (mcb_pwm_sel_t'(map_code))
            MCB_PWM1:     pwm_quiet = pwm_duty_zero[0] | pwm_fan_off[0];
            MCB_PWM2:     pwm_quiet = pwm_duty_zero[1] | pwm_fan_off[1];
            MCB_PWM3:     pwm_quiet = pwm_duty_zero[2] | pwm_fan_off[2];
            MCB_PWM_RSVD: pwm_quiet = 1'b1;
        endcase
    end

    assign status_set = tach_event & enable & ~pwm_quiet & ~min_all_ones;

    // ============================================================
    // Checks
    property p_min_block;
        @(posedge core_clk) disable iff (sys_rst)
        min_all_ones |-> !status_set;
    endproperty
    a_min_block: assert property (p_min_block)
        else $error("tach status set with all-ones minimum");

    property p_quiet_block;
        @(posedge core_clk) disable iff (sys_rst)
        (map_code == MCB_PWM1 && pwm_duty_zero[0]) |-> !status_set;
    endproperty
    a_quiet_block: assert property (p_quiet_block)
        else $error("tach status set with zero duty on PWM1");
endmodule

// ===== rtl/mcb_bank.sv
// Configuration and event-enable register bank
`timescale 1ns/100ps
`include "mcb_consts.svh"
module mcb_bank
    import mcb_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Register port from the management bus engine
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire mcb_byte_t  reg_wr_data,
    input  wire logic       reg_rd_en,
    output mcb_byte_t       reg_rd_data,
    output logic            reg_hit,
    input  wire logic       lock_active,
    // Monitor status
    input  wire logic       monitor_start,
    input  wire logic       readings_updated,
    // Raw events
    input  wire logic [7:0] rail_limit_event,
    input  wire logic [1:0] diode_alarm_event,
    input  wire logic [3:0] tach_event,
    input  wire logic       room_temp_event,
    // Fan state
    input  wire logic [2:0] pwm_duty_zero,
    input  wire logic [2:0] pwm_fan_off,
    input  wire logic [3:0] tach_min_all_ones,
    input  wire logic       sync_pulse_req,
    // Gated status sets
    output logic [7:0]      rail_status_set,
    output logic [1:0]      diode_status_set,
    output logic [3:0]      tach_status_set,
    output logic            room_status_set,
    // Mode outputs
    output logic            idle_power_select,
    output logic            scan_pattern_select,
    output logic            offset_target_select,
    output logic            sample_count_select,
    output logic [7:0]      diode_avg_count,
    output logic [7:0]      rail_avg_count,
    output logic            spinup_shortening_enable,
    output logic            tach_self_check_mode,
    output logic            init_request,
    output logic [7:0]      tach_to_pwm_map,
    // Alert pin, open drain
    output logic            alert_pin_n_o,
    output logic            alert_pin_n_oe,
    // Sync pulse, active low
    output logic            sync_pulse_n
);
    mcb_byte_t sfc_val;
    mcb_byte_t volt_val;
    mcb_byte_t cfg_val;
    mcb_byte_t ft_val;
    mcb_byte_t sync_val;
    mcb_byte_t rd_data_reg;
    mcb_byte_t rd_data_next;
    logic      valid_reg;
    logic      valid_next;
    logic      alert_reg;
    logic      alert_next;
    logic      pin_enabled;
    logic      fan_any;
    logic      temp_any;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // ============================================================
    // Register cells
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_SFC), .WR_MASK(`MCB_WM_ALL)) u_sfc (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_SFC)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (sfc_val)
    );
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_VOLT_EN), .WR_MASK(`MCB_WM_ALL)) u_volt (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_VOLT_EN)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (volt_val)
    );
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_CFG), .WR_MASK(`MCB_WM_CFG)) u_cfg (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_CFG)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (cfg_val)
    );
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_FT_EN), .WR_MASK(`MCB_WM_FT_EN)) u_ft (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_FT_EN)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (ft_val)
    );
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_TACH_MAP), .WR_MASK(`MCB_WM_ALL)) u_map (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_TACH_MAP)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (tach_to_pwm_map)
    );
    mcb_lock_reg #(.RESET_VAL(`MCB_RST_SYNC), .WR_MASK(`MCB_WM_SYNC)) u_sync (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr_hit      (reg_wr_en && hit(reg_addr, `MCB_OFF_SYNC)),
        .lock_active (lock_active),
        .wr_data     (reg_wr_data),
        .value       (sync_val)
    );

    // ============================================================
    // Mode fields
    assign idle_power_select        = sfc_val[`MCB_SFC_IDLE];
    assign scan_pattern_select      = sfc_val[`MCB_SFC_SCAN];
    assign offset_target_select     = sfc_val[`MCB_SFC_OFFSET];
    assign sample_count_select      = sfc_val[`MCB_SFC_AVG];
    assign diode_avg_count          = sample_count_select ? `MCB_AVG_DIODE_FAST
                                                          : `MCB_AVG_DIODE_DEEP;
    assign rail_avg_count           = sample_count_select ? `MCB_AVG_RAIL_FAST
                                                          : `MCB_AVG_RAIL_DEEP;
    assign spinup_shortening_enable = cfg_val[`MCB_CFG_SPINUP];
    assign tach_self_check_mode     = cfg_val[`MCB_CFG_TACH_TEST];
    assign init_request             = cfg_val[`MCB_CFG_INIT];

    // ============================================================
    // Event gating
    assign rail_status_set     = rail_limit_event & volt_val;
    assign diode_status_set[0] = diode_alarm_event[0] & sfc_val[`MCB_SFC_D1];
    assign diode_status_set[1] = diode_alarm_event[1] & sfc_val[`MCB_SFC_D2];
    assign room_status_set     = room_temp_event & ft_val[`MCB_FT_ROOM];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_tach
            mcb_tach_gate u_gate (
                .core_clk      (core_clk),
                .sys_rst       (sys_rst),
                .map_code      (tach_to_pwm_map[2*gi+1 -: 2]),
                .pwm_duty_zero (pwm_duty_zero),
                .pwm_fan_off   (pwm_fan_off),
                .min_all_ones  (tach_min_all_ones[gi]),
                .enable        (ft_val[`MCB_FT_FAN_LO + gi]),
                .tach_event    (tach_event[gi]),
                .status_set    (tach_status_set[gi])
            );
        end
    endgenerate

    // ============================================================
    // Alert pin; registered so the pad never sees decode glitches
    assign pin_enabled = sfc_val[`MCB_SFC_PIN_EN] & cfg_val[`MCB_CFG_ALERT];
    assign fan_any     = |tach_status_set;
    assign temp_any    = (|diode_status_set) | room_status_set;

    always_comb
    begin
        alert_next = pin_enabled &
                     ((|rail_status_set & sfc_val[`MCB_SFC_RAIL_PIN]) |
                      (fan_any & ft_val[`MCB_FT_FAN_PIN]) |
                      (temp_any & ft_val[`MCB_FT_TEMP_PIN]));
    end

    // ============================================================
    // Readings valid flag; an update while monitor_start is low does not set it
    always_comb
    begin
        valid_next = monitor_start & (valid_reg | readings_updated);
    end

    // ============================================================
    // Read path
    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (reg_rd_en)
        begin
            unique case (1'b1)
                hit(reg_addr, `MCB_OFF_SFC):      rd_data_next = sfc_val;
                hit(reg_addr, `MCB_OFF_VOLT_EN):  rd_data_next = volt_val;
                hit(reg_addr, `MCB_OFF_CFG):
                begin
                    rd_data_next = cfg_val;
                    rd_data_next[`MCB_CFG_VALID] = valid_reg;
                end
                hit(reg_addr, `MCB_OFF_FT_EN):    rd_data_next = ft_val;
                hit(reg_addr, `MCB_OFF_TACH_MAP): rd_data_next = tach_to_pwm_map;
                hit(reg_addr, `MCB_OFF_SYNC):     rd_data_next = sync_val;
                default:                          rd_data_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_data_reg <= 8'h00;
            valid_reg   <= 1'b0;
            alert_reg   <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            valid_reg   <= valid_next;
            alert_reg   <= alert_next;
        end
    end

    assign reg_rd_data    = rd_data_reg;
    assign reg_hit        = hit(reg_addr, `MCB_OFF_SFC) | hit(reg_addr, `MCB_OFF_VOLT_EN) |
                            hit(reg_addr, `MCB_OFF_CFG) | hit(reg_addr, `MCB_OFF_FT_EN) |
                            hit(reg_addr, `MCB_OFF_TACH_MAP) | hit(reg_addr, `MCB_OFF_SYNC);
    assign alert_pin_n_o  = 1'b0;
    assign alert_pin_n_oe = alert_reg;
    assign sync_pulse_n   = ~(sync_pulse_req & ~sync_val[`MCB_SYNC_ON]);   // bit low = on

    // ============================================================
    // Checks
    sequence s_sfc_write;
        reg_wr_en && !lock_active && reg_addr == `MCB_OFF_SFC;
    endsequence

    property p_idle_sel;
        @(posedge core_clk) disable iff (sys_rst)
        s_sfc_write |=> (idle_power_select == $past(reg_wr_data[0]));
    endproperty
    a_idle_sel: assert property (p_idle_sel)
        else $error("idle power select did not take the write");

    property p_scan_sel;
        @(posedge core_clk) disable iff (sys_rst)
        s_sfc_write |=> (scan_pattern_select == $past(reg_wr_data[1]));
    endproperty
    a_scan_sel: assert property (p_scan_sel)
        else $error("scan pattern select did not take the write");

    property p_pin_gate;
        @(posedge core_clk) disable iff (sys_rst)
        !pin_enabled |=> !alert_pin_n_oe;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("alert pin driven while disabled");

    property p_rail_pin;
        @(posedge core_clk) disable iff (sys_rst)
        (pin_enabled && sfc_val[`MCB_SFC_RAIL_PIN] && (|rail_status_set)) |=> alert_pin_n_oe;
    endproperty
    a_rail_pin: assert property (p_rail_pin)
        else $error("rail event failed to assert alert pin");

    property p_avg;
        @(posedge core_clk) disable iff (sys_rst)
        sample_count_select ? (diode_avg_count == 8'h10 && rail_avg_count == 8'h01)
                            : (diode_avg_count == 8'h80 && rail_avg_count == 8'h08);
    endproperty
    a_avg: assert property (p_avg)
        else $error("averaging depth wrong");

    property p_diode_gate;
        @(posedge core_clk) disable iff (sys_rst)
        (diode_status_set[1] |-> sfc_val[`MCB_SFC_D2]) and
        (diode_status_set[0] |-> sfc_val[`MCB_SFC_D1]);
    endproperty
    a_diode_gate: assert property (p_diode_gate)
        else $error("diode status set while disabled");

    sequence s_cfg_read;
        reg_rd_en && reg_addr == `MCB_OFF_CFG;
    endsequence

    property p_valid_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (!monitor_start ##1 s_cfg_read) |=> !reg_rd_data[`MCB_CFG_VALID];
    endproperty
    a_valid_clear: assert property (p_valid_clear)
        else $error("readings valid shown without start");

    property p_sync_off;
        @(posedge core_clk) disable iff (sys_rst)
        sync_val[`MCB_SYNC_ON] |-> sync_pulse_n;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync pulse active while switched off");

    property p_unmapped_read;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd_en && !reg_hit) |=> (reg_rd_data == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero");
endmodule

// ===== bench/mcb_host_model.sv
// Host model driving the bank's register port
`timescale 1ns/100ps
module mcb_host_model
    import mcb_pkg::*;
(
    // Clock
    input  wire logic      core_clk,
    // Register port
    output logic [7:0]     reg_addr,
    output logic           reg_wr_en,
    output mcb_byte_t      reg_wr_data,
    output logic           reg_rd_en,
    input  wire mcb_byte_t reg_rd_data
);
    // ============================================================
    // Idle lines
    initial
    begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // ============================================================
    // Transfers, one byte each
    // Inverse on release so stale values never pass
    task automatic wr(input logic [7:0] a, input mcb_byte_t d);
        @(negedge core_clk);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = 1'b1;
        @(negedge core_clk);
        reg_wr_en   = 1'b0;
        reg_addr    = ~a;
        reg_wr_data = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output mcb_byte_t d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        d         = reg_rd_data;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
    endtask
endmodule

// ===== bench/mcb_bank_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
module mcb_bank_tb
    import mcb_pkg::*;
;
    // ============================================================
    // Signals
    logic       core_clk, sys_rst, reg_wr_en, reg_rd_en, reg_hit, lock_active;
    logic [7:0] reg_addr, rail_limit_event, rail_status_set, diode_avg_count;
    logic [7:0] rail_avg_count, tach_to_pwm_map;
    mcb_byte_t  reg_wr_data, reg_rd_data;
    logic       monitor_start, readings_updated, room_temp_event, sync_pulse_req;
    logic [1:0] diode_alarm_event, diode_status_set;
    logic [3:0] tach_event, tach_min_all_ones, tach_status_set;
    logic [2:0] pwm_duty_zero, pwm_fan_off;
    logic       room_status_set, idle_power_select, scan_pattern_select;
    logic       offset_target_select, sample_count_select, spinup_shortening_enable;
    logic       tach_self_check_mode, init_request, alert_pin_n_o, alert_pin_n_oe;
    logic       sync_pulse_n;
    int         errors, cmp_count, cycles;
    mcb_byte_t  cur [6];
    mcb_byte_t  got;
    localparam mcb_byte_t OFFS [6] = '{8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h81, 8'h83};
    localparam mcb_byte_t RSTS [6] = '{8'hE0, 8'hEC, 8'h10, 8'h5E, 8'hA4, 8'h62};
    localparam mcb_byte_t WMS [6]  = '{8'hFF, 8'hFF, 8'hD2, 8'h7F, 8'hFF, 8'h10};

    // ============================================================
    // Design and host
    mcb_bank dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_hit(reg_hit), .lock_active(lock_active),
        .monitor_start(monitor_start), .readings_updated(readings_updated),
        .rail_limit_event(rail_limit_event), .diode_alarm_event(diode_alarm_event),
        .tach_event(tach_event), .room_temp_event(room_temp_event),
        .pwm_duty_zero(pwm_duty_zero), .pwm_fan_off(pwm_fan_off),
        .tach_min_all_ones(tach_min_all_ones), .sync_pulse_req(sync_pulse_req),
        .rail_status_set(rail_status_set), .diode_status_set(diode_status_set),
        .tach_status_set(tach_status_set), .room_status_set(room_status_set),
        .idle_power_select(idle_power_select), .scan_pattern_select(scan_pattern_select),
        .offset_target_select(offset_target_select),
        .sample_count_select(sample_count_select), .diode_avg_count(diode_avg_count),
        .rail_avg_count(rail_avg_count), .spinup_shortening_enable(spinup_shortening_enable),
        .tach_self_check_mode(tach_self_check_mode), .init_request(init_request),
        .tach_to_pwm_map(tach_to_pwm_map), .alert_pin_n_o(alert_pin_n_o),
        .alert_pin_n_oe(alert_pin_n_oe), .sync_pulse_n(sync_pulse_n));
    mcb_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

    // ============================================================
    // Helpers
    task automatic chk(input string n, input mcb_byte_t s, input mcb_byte_t e);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Locked writes keep the old expectation
    task automatic wreg(input int i, input mcb_byte_t d);
        host_u.wr(OFFS[i], d);
        if (lock_active !== 1'b1)
            cur[i] = (d & WMS[i]) | (RSTS[i] & ~WMS[i]);
    endtask

    task automatic rreg(input int i);
        host_u.rd(OFFS[i], got);
        chk("reg_rd_data", got, cur[i]);
    endtask

    task automatic tach(input logic [2:0] dz, input logic [2:0] fo, input logic [3:0] mn,
                        input logic [3:0] e);
        @(negedge core_clk);
        pwm_duty_zero     = dz;
        pwm_fan_off       = fo;
        tach_min_all_ones = mn;
        #1;
        chk("tach_status_set", {4'h0, tach_status_set}, {4'h0, e});
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
            rreg(i);
        host_u.rd(8'h7D, got);
        chk("unmapped", got, 8'h00);
        chk("modes", {idle_power_select, scan_pattern_select, offset_target_select,
            sample_count_select, spinup_shortening_enable, alert_pin_n_oe, reg_hit,
            init_request}, 8'h18);
        chk("sync_pulse_n", {7'h0, sync_pulse_n}, 8'h00);
    endtask

    task automatic t_modes();
        wreg(0, 8'h01);
        rreg(0);
        chk("idle", {7'h0, idle_power_select}, 8'h01);
        wreg(0, 8'h1E);
        chk("scan_offset", {6'h0, scan_pattern_select, offset_target_select}, 8'h03);
        chk("diode_avg", diode_avg_count, 8'h80);
        chk("rail_avg", rail_avg_count, 8'h08);
        wreg(0, 8'hE0);
        chk("avg_fast", {diode_avg_count[7:4], rail_avg_count[3:0]}, 8'h11);
    endtask

    task automatic t_reserved();
        for (int i = 2; i < 6; i++)
        begin
            wreg(i, 8'hFF);
            rreg(i);
        end
        chk("sync_off", {tach_self_check_mode, init_request, 5'h0, sync_pulse_n}, 8'hC1);
        wreg(5, 8'h00);
        rreg(5);
        chk("sync_on", {7'h0, sync_pulse_n}, 8'h00);
        wreg(2, 8'h02);
        chk("spinup", {7'h0, spinup_shortening_enable}, 8'h00);
        wreg(3, 8'h5E);
        wreg(4, 8'hA4);
    endtask

    task automatic t_events();
        wreg(1, 8'hA5);
        @(negedge core_clk);
        rail_limit_event  = 8'hFF;
        diode_alarm_event = 2'b11;
        room_temp_event   = 1'b1;
        tach_event        = 4'hF;
        #1;
        chk("rail_status", rail_status_set, 8'hA5);
        chk("diode_status", {6'h0, diode_status_set}, 8'h03);
        chk("room_status", {7'h0, room_status_set}, 8'h01);
        tach(3'b000, 3'b000, 4'h0, 4'hF);
        tach(3'b100, 3'b000, 4'h0, 4'h3);
        tach(3'b000, 3'b001, 4'h2, 4'hC);
        wreg(4, 8'h1B);
        chk("tach_map", tach_to_pwm_map, 8'h1B);
        tach(3'b001, 3'b000, 4'h0, 4'h6);
        wreg(3, 8'h02);
        wreg(0, 8'h60);
        #1;
        chk("room_off", {7'h0, room_status_set}, 8'h00);
        chk("diode_one", {6'h0, diode_status_set}, 8'h01);
        tach(3'b000, 3'b000, 4'h0, 4'h0);
    endtask

    task automatic t_alert();
        wreg(1, 8'hEC);
        wreg(0, 8'hEC);
        wreg(2, 8'h12);
        @(negedge core_clk);
        rail_limit_event = 8'h04;
        @(negedge core_clk);
        chk("alert_on", {7'h0, alert_pin_n_oe}, 8'h01);
        chk("alert_o", {7'h0, alert_pin_n_o}, 8'h00);
        wreg(0, 8'hE4);
        @(negedge core_clk);
        chk("alert_no_rail", {7'h0, alert_pin_n_oe}, 8'h00);
        wreg(0, 8'hE8);
        @(negedge core_clk);
        chk("alert_no_pin", {7'h0, alert_pin_n_oe}, 8'h00);
        wreg(0, 8'hEC);
        wreg(2, 8'h10);
        @(negedge core_clk);
        chk("alert_no_cfg", {7'h0, alert_pin_n_oe}, 8'h00);
        rail_limit_event = 8'h00;
    endtask

    task automatic t_valid_lock();
        rreg(2);
        @(negedge core_clk);
        monitor_start    = 1'b1;
        readings_updated = 1'b1;
        @(negedge core_clk);
        readings_updated = 1'b0;
        host_u.rd(OFFS[2], got);
        chk("valid_set", got, cur[2] | 8'h08);
        monitor_start = 1'b0;
        rreg(2);
        lock_active = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            wreg(i, ~cur[i]);
            rreg(i);
        end
        lock_active = 1'b0;
    endtask

    // ============================================================
    // Clock, timeout and main sequence
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Whole run takes under two hundred cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        sys_rst = 1'b1;
        lock_active = 1'b0;
        monitor_start = 1'b0;
        readings_updated = 1'b0;
        rail_limit_event = 8'h00;
        diode_alarm_event = 2'b00;
        tach_event = 4'h0;
        room_temp_event = 1'b0;
        pwm_duty_zero = 3'b000;
        pwm_fan_off = 3'b000;
        tach_min_all_ones = 4'h0;
        sync_pulse_req = 1'b1;
        cur = RSTS;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_modes();
        t_reserved();
        t_events();
        t_alert();
        t_valid_lock();
        stop_test();
    end
endmodule
